// ---- psl_pkg.sv ----
package psl_pkg;

  // strap defaults when a pin is left to its pull
  localparam logic DEF_AUTO_XOVER  = 1'b1;
  localparam logic DEF_MANUAL_XOV  = 1'b0;
  localparam logic DEF_NEGOTIATE   = 1'b1;
  localparam logic DEF_SPEED       = 1'b1;
  localparam logic DEF_DUPLEX      = 1'b1;
  localparam logic DEF_ENERGY_SAVE = 1'b1;

  // operating setting field encodings (three bits)
  localparam logic [2:0] SET_10_HALF  = 3'h0;
  localparam logic [2:0] SET_10_FULL  = 3'h1;
  localparam logic [2:0] SET_100_HALF = 3'h2;
  localparam logic [2:0] SET_100_FULL = 3'h3;
  localparam logic [2:0] SET_AN_ALL   = 3'h7;

  typedef struct packed {
    logic energy_saving;
    logic auto_xover;
    logic manual_xover;
    logic negotiate;
    logic speed;
    logic duplex;
  } psl_straps_t;

  typedef struct packed {
    logic lpi_enable;
    logic lpi_capability;
    logic lpi_advert;
  } psl_xcvr_a_t;

  typedef struct packed {
    logic       auto_xover_state;
    logic       auto_xover_en;
    logic       crossed_wiring;
    logic       negotiate_en;
    logic       speed_low;
    logic       duplex;
    logic       adv_10_full;
    logic       adv_10_half;
    logic [2:0] op_setting;
  } psl_xcvr_b_t;

endpackage

// ---- psl_loader.sv ----
`timescale 1ns/1ps
// Summary of operation
// R1: the energy-saving strap gives the reset default of transceiver A's low-power-idle enable bit.
// R2: the same strap gives the default of transceiver A's 100BASE-TX low-power-idle capability bit.
// R3: the same strap gives the default of transceiver A's 100BASE-TX low-power-idle advertisement bit.
// R4: in fiber mode a transceiver's energy, crossover, negotiation and speed straps have no effect.
// R5: the auto-crossover strap (default one) gives the default of port B's crossover strap-state bit.
// R6: with source-select on straps, crossover comes from the auto and manual crossover straps.
// R7: with auto strap low and straps selected, manual value 0 is straight wiring and 1 crossed.
// R8: the negotiation strap (default one) gives the default of transceiver B's negotiation enable bit.
// R9: the negotiation strap also shapes speed-low, duplex, 10BASE-T adverts and the setting field.
// R10: the speed strap (default one) shapes speed-low, 10BASE-T adverts and the setting field.
// R11: the duplex strap (default one) shapes duplex, the 10BASE-T full advert and the setting field.
// R12: straps are caught once at reset release; later software writes override, save crossover control while the selector is high, until the next reset.
module psl_loader (
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_b_i,
  input  wire psl_pkg::psl_straps_t straps_i,
  input  wire logic                 xcvr_a_fiber_i,
  input  wire logic                 xcvr_b_fiber_i,
  input  wire logic                 crossover_source_select_i,
  input  wire logic                 sw_a_wr_i,
  input  wire psl_pkg::psl_xcvr_a_t sw_a_data_i,
  input  wire logic                 sw_b_wr_i,
  input  wire psl_pkg::psl_xcvr_b_t sw_b_data_i,
  output logic                      straps_loaded_o,
  output psl_pkg::psl_xcvr_a_t      xcvr_a_o,
  output psl_pkg::psl_xcvr_b_t      xcvr_b_o
);
  import psl_pkg::*;

  logic        rst_meta_reg;
  logic        rst_sync_b_reg;
  logic        loaded_reg;
  psl_xcvr_a_t a_reg;
  psl_xcvr_a_t a_next;
  psl_xcvr_b_t b_reg;
  psl_xcvr_b_t b_next;
  logic        b_neg;
  logic        b_spd;
  logic        b_dup;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_reg   <= 1'b0;
      rst_sync_b_reg <= 1'b0;
    end else begin
      rst_meta_reg   <= 1'b1;
      rst_sync_b_reg <= rst_meta_reg;
    end
  end

  // transceiver A defaults; fiber forces low-power idle off since it cannot be negotiated
  always_comb begin
    a_next.lpi_enable     = straps_i.energy_saving & ~xcvr_a_fiber_i; // R1 R4
    a_next.lpi_capability = straps_i.energy_saving & ~xcvr_a_fiber_i; // R2 R4
    a_next.lpi_advert     = straps_i.energy_saving & ~xcvr_a_fiber_i; // R3 R4
  end

  // transceiver B: in fiber mode speed and crossover state take their defaults; negotiation and crossover control are forced off
  always_comb begin
    b_neg = xcvr_b_fiber_i ? 1'b0 : straps_i.negotiate;     // R4
    b_spd = xcvr_b_fiber_i ? DEF_SPEED : straps_i.speed;    // R4
    b_dup = straps_i.duplex;                                // duplex still applies to fiber
    b_next.auto_xover_state = xcvr_b_fiber_i ? DEF_AUTO_XOVER : straps_i.auto_xover; // R5 R4
    b_next.auto_xover_en    = 1'b0;
    b_next.crossed_wiring   = 1'b0;
    if (!xcvr_b_fiber_i) begin
      b_next.auto_xover_en  = straps_i.auto_xover;                           // R6
      b_next.crossed_wiring = ~straps_i.auto_xover & straps_i.manual_xover; // R7
    end
    b_next.negotiate_en = b_neg;                                          // R8
    b_next.speed_low    = b_neg | b_spd;                                  // R9 R10
    b_next.duplex       = b_neg | b_dup;                                  // R9 R11
    b_next.adv_10_full  = b_neg ? 1'b1 : (~b_spd & b_dup);                // R9 R10 R11
    b_next.adv_10_half  = b_neg ? 1'b1 : ~b_spd;                          // R9 R10
    if (b_neg) begin
      b_next.op_setting = SET_AN_ALL;                                     // R9
    end else begin
      case ({b_spd, b_dup})                                               // R10 R11
        2'b00:   b_next.op_setting = SET_10_HALF;
        2'b01:   b_next.op_setting = SET_10_FULL;
        2'b10:   b_next.op_setting = SET_100_HALF;
        default: b_next.op_setting = SET_100_FULL;
      endcase
    end
  end

  // load once in the first cycle after release, then software owns the bits, except crossover control while the selector is high
  always_ff @(posedge core_clk_i or negedge rst_sync_b_reg) begin
    if (!rst_sync_b_reg) begin
      loaded_reg <= 1'b0;
    end else begin
      loaded_reg <= 1'b1; // R12
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_sync_b_reg) begin
    if (!rst_sync_b_reg) begin
      a_reg <= '0;
    end else if (!loaded_reg) begin
      a_reg <= a_next; // R12
    end else if (sw_a_wr_i) begin
      a_reg <= sw_a_data_i; // R12
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_sync_b_reg) begin
    if (!rst_sync_b_reg) begin
      b_reg <= '0;
    end else if (!loaded_reg) begin
      b_reg <= b_next; // R12
    end else if (sw_b_wr_i) begin
      // selector low hands crossover control to software; high keeps the current crossover control bits
      b_reg <= sw_b_data_i;
      if (crossover_source_select_i) begin
        b_reg.auto_xover_en  <= b_reg.auto_xover_en;  // R6
        b_reg.crossed_wiring <= b_reg.crossed_wiring; // R7
      end
    end
  end

  assign straps_loaded_o = loaded_reg;
  assign xcvr_a_o        = a_reg;
  assign xcvr_b_o        = b_reg;

endmodule // psl_loader

// ---- psl_loader_chk.sv ----
`timescale 1ns/1ps
module psl_loader_chk import psl_pkg::*; (
  input wire logic        core_clk_i,
  input wire logic        rst_b_i,
  input wire psl_straps_t straps_i,
  input wire logic        xcvr_a_fiber_i,
  input wire logic        xcvr_b_fiber_i,
  input wire logic        crossover_source_select_i,
  input wire logic        sw_a_wr_i,
  input wire psl_xcvr_a_t sw_a_data_i,
  input wire logic        sw_b_wr_i,
  input wire psl_xcvr_b_t sw_b_data_i,
  input wire logic        straps_loaded_o,
  input wire psl_xcvr_a_t xcvr_a_o,
  input wire psl_xcvr_b_t xcvr_b_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic ldq, ld;
  always_ff @(posedge core_clk_i) ldq <= straps_loaded_o;
  // straps are steady by then, so the live pins stand for the sampled ones
  assign ld = straps_loaded_o & !ldq;
  property p_en; ld |-> xcvr_a_o.lpi_enable == (straps_i.energy_saving & !xcvr_a_fiber_i); endproperty
  a_en: assert property (p_en) else $error("lpi enable default");
  property p_cap; ld |-> (xcvr_a_o.lpi_capability == (straps_i.energy_saving & !xcvr_a_fiber_i)) &&
    (xcvr_a_o.lpi_advert == (straps_i.energy_saving & !xcvr_a_fiber_i)); endproperty
  a_cap: assert property (p_cap) else $error("lpi cap or advert default");
  property p_xs; ld && !xcvr_b_fiber_i |-> xcvr_b_o.auto_xover_state == straps_i.auto_xover; endproperty
  a_xs: assert property (p_xs) else $error("crossover state default");
  property p_xw; ld && !xcvr_b_fiber_i |-> xcvr_b_o.crossed_wiring == (straps_i.manual_xover & !straps_i.auto_xover);
  endproperty
  a_xw: assert property (p_xw) else $error("wiring default");
  property p_an; ld |-> xcvr_b_o.negotiate_en == (straps_i.negotiate & !xcvr_b_fiber_i); endproperty
  a_an: assert property (p_an) else $error("negotiation default");
  property p_op; ld |-> xcvr_b_o.op_setting == ((straps_i.negotiate & !xcvr_b_fiber_i) ? SET_AN_ALL :
    {1'b0, straps_i.speed | xcvr_b_fiber_i, straps_i.duplex}); endproperty
  a_op: assert property (p_op) else $error("setting field default");
  property p_lock; straps_loaded_o && sw_b_wr_i && crossover_source_select_i |=> $stable(xcvr_b_o.crossed_wiring); endproperty
  a_lock: assert property (p_lock) else $error("wiring changed by write");
  property p_wr; straps_loaded_o && sw_a_wr_i |=> xcvr_a_o == $past(sw_a_data_i); endproperty
  a_wr: assert property (p_wr) else $error("write a lost");
endmodule // psl_loader_chk
bind psl_loader psl_loader_chk chk (.*);

// ---- psl_strap_board.sv ----
`timescale 1ns/1ps
module psl_strap_board import psl_pkg::*; (
  input  wire logic        fit_i,
  input  wire psl_straps_t level_i,
  output psl_straps_t      straps_o
);
  // no resistor fitted leaves every pin to its pull
  assign straps_o = fit_i ? level_i : {DEF_ENERGY_SAVE, DEF_AUTO_XOVER, DEF_MANUAL_XOV, DEF_NEGOTIATE, DEF_SPEED,
                                       DEF_DUPLEX};
endmodule // psl_strap_board

// ---- psl_loader_tb.sv ----
`timescale 1ns/1ps
module psl_loader_tb;
  import psl_pkg::*;
  logic core_clk_i = 0, rst_b_i = 0, fa = 0, fb = 0, sel = 1, fit = 0, wa = 0, wb = 0, ld, n, sp;
  psl_straps_t lv = '0, st;
  psl_xcvr_a_t da = '0, ya;
  psl_xcvr_b_t db = '0, yb;
  int errors = 0, n_tests = 0, cyc = 0;
  always #4 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (++cyc > 9000) begin errors++; conclude(); end
  psl_strap_board brd (.fit_i(fit), .level_i(lv), .straps_o(st));
  psl_loader uut (.core_clk_i, .rst_b_i, .straps_i(st), .xcvr_a_fiber_i(fa), .xcvr_b_fiber_i(fb),
    .crossover_source_select_i(sel), .sw_a_wr_i(wa), .sw_a_data_i(da), .sw_b_wr_i(wb), .sw_b_data_i(db),
    .straps_loaded_o(ld), .xcvr_a_o(ya), .xcvr_b_o(yb));
  task automatic cmp(string nm, logic [10:0] x, logic [10:0] g);
    n_tests++;
    if (g !== x) begin errors++; $display("MISMATCH %s exp %h got %h", nm, x, g); end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // a write held high through reset must not disturb the loaded defaults
  task automatic load(logic [8:0] v);
    {fit, fb, fa, lv} = v;
    {rst_b_i, sel, wa, wb, da} = 7'h35;
    repeat (5) @(posedge core_clk_i);
    #1 rst_b_i = 1;
    repeat (8) if (ld !== 1'b1) @(posedge core_clk_i) #1;
    n = st.negotiate & !fb;
    sp = st.speed | fb;
    cmp("loaded", 1, ld);
    cmp("a", {8'h0, {3{st.energy_saving & !fa}}}, ya);
    cmp("b", {st.auto_xover | fb, st.auto_xover & !fb, !st.auto_xover & st.manual_xover & !fb, n, n | sp,
      n | st.duplex, n | !sp & st.duplex, n | !sp, n ? SET_AN_ALL : {1'b0, sp, st.duplex}}, yb);
    // one more edge out of reset so the checker sees the freshly loaded defaults
    @(posedge core_clk_i) #1;
  endtask
  task automatic wr;
    load(9'h1ff);
    da = 3'h2;
    @(posedge core_clk_i) #1 cmp("a1", 3'h2, ya);
    da = 3'h6;
    @(posedge core_clk_i) #1 cmp("a2", 3'h6, ya);
    {wa, sel, wb, db} = 14'h0aa5;
    @(posedge core_clk_i) #1 cmp("b1", 11'h2a5, yb);
    {sel, db} = 12'h95a;
    @(posedge core_clk_i) #1 wb = 0;
    cmp("bx", 2'h2, yb[9:8]);
    cmp("bo", 8'h5a, yb[7:0]);
    load(9'h0aa);
  endtask
  initial begin
    for (int i = 0; i < 512; i++) load(i[8:0]);
    $display("test load done");
    wr();
    $display("test write done");
    conclude();
  end
endmodule // psl_loader_tb
